// ==== rtl/serial_port_defines.vh ====
// Constants for the jumper-configured asynchronous serial port.
// Assumes a 25 MHz core clock; included by the port's design file.
// Summary of operation
// RQ1 - Jumpers sampled only at reset release
// RQ2 - Word jumper installed: 7 bits, else 8
// RQ3 - Stop jumper installed: 2 stops, else 1
// RQ4 - Sense jumper installed: even, else odd parity
// RQ5 - Parity jumper: generate and check parity
// RQ6 - Parity off ignores sense jumper entirely
// RQ7 - Eight bits with parity: one stop bit
// RQ8 - Three rate jumpers select 110 to 19200 baud
// RQ9 - Host spaces characters for 800 us handling
// RQ10 - Both ends share rate, parity, width
// RQ11 - Transmit on txd, receive on rxd
// RQ12 - Request-to-send true before each transmission
// RQ13 - Terminal-ready held true while powered
// RQ14 - Handshake inputs ignored, read true open
// RQ15 - Host should prefer 19200, 7 bits, parity
// RQ16 - Start, data LSB first, parity, stops
// RQ17 - Centre sampling, parity and framing errors
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

`define CLK_HZ          25000000
`define RX_PROC_TIME_US 800
`define RX_PROC_CYCLES  ((`RX_PROC_TIME_US * (`CLK_HZ / 1000000)))

// Cycles per bit, rounded down, for each rate code
`define DIV_110         (`CLK_HZ / 110)
`define DIV_300         (`CLK_HZ / 300)
`define DIV_600         (`CLK_HZ / 600)
`define DIV_1200        (`CLK_HZ / 1200)
`define DIV_2400        (`CLK_HZ / 2400)
`define DIV_4800        (`CLK_HZ / 4800)
`define DIV_9600        (`CLK_HZ / 9600)
`define DIV_19200       (`CLK_HZ / 19200)

`define DIV_W           18
`define RTS_LEAD_BITS   1

`endif

// ==== rtl/serial_port.v ====
// Jumper-configured asynchronous serial port, data terminal side.
// Assumes jumpers and rxd are asynchronous pins; tx bytes come from
// logic on core_clk with a valid/ready handshake.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_defines.vh"

module serial_port (
    input  wire       core_clk,
    input  wire       reset_n,
    input  wire       seven_bit_word_select,
    input  wire       two_stop_select,
    input  wire       parity_sense_even_select,
    input  wire       parity_enable_select,
    input  wire       rate_select_msb,
    input  wire       rate_select_mid,
    input  wire       rate_select_lsb,
    input  wire       rxd,
    input  wire       dsr_n,
    input  wire       cts_n,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output reg        tx_ready,
    output reg        txd,
    output reg        rts,
    output reg        dtr,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        rx_parity_err,
    output reg        rx_frame_err
);

////////////////////////////////////////////////////////////////////////
// Reset release and jumper capture

reg        rst_m_q;
reg        rst_q;
reg        cfg_take_q;
reg        cfg_seven_q;
reg        cfg_two_stop_q;
reg        cfg_even_q;
reg        cfg_pe_q;
reg  [2:0] cfg_rate_q;
reg  [6:0] jmp_s1_q;
reg  [6:0] jmp_s2_q;
reg  [6:0] jmp_s3_q;
reg  [6:0] jmp_lvl_q;
wire [6:0] jmp_agree_w = ~(jmp_s2_q ^ jmp_s3_q);

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        rst_m_q <= 1'b0;
        rst_q   <= 1'b0;
    end else begin
        rst_m_q <= 1'b1;
        rst_q   <= rst_m_q;
    end
end

// Straps pass three stages; a bit moves once stages two and three agree.
// No reset here: the straps must settle while reset is still held.
always @(posedge core_clk) begin
    jmp_s1_q  <= {seven_bit_word_select, two_stop_select,
                  parity_sense_even_select, parity_enable_select,
                  rate_select_msb, rate_select_mid, rate_select_lsb};
    jmp_s2_q  <= jmp_s1_q;
    jmp_s3_q  <= jmp_s2_q;
    jmp_lvl_q <= (jmp_agree_w & jmp_s3_q) | (~jmp_agree_w & jmp_lvl_q);
end

// Jumpers are static straps; captured once, one cycle after release
always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
        cfg_take_q     <= 1'b1;
        cfg_seven_q    <= 1'b0;
        cfg_two_stop_q <= 1'b0;
        cfg_even_q     <= 1'b0;
        cfg_pe_q       <= 1'b0;
        cfg_rate_q     <= 3'h0;
    end else if (cfg_take_q) begin
        cfg_take_q     <= 1'b0;                                 // RQ1
        cfg_seven_q    <= jmp_lvl_q[6];
        cfg_two_stop_q <= jmp_lvl_q[5];
        cfg_even_q     <= jmp_lvl_q[4];
        cfg_pe_q       <= jmp_lvl_q[3];
        cfg_rate_q     <= jmp_lvl_q[2:0];                       // RQ8
    end
end

// The quotient is 32 bits wide; cut on purpose to the counter width
function [`DIV_W-1:0] bit_div;
    input [2:0]  code;
    reg   [31:0] full;
    begin
        case (code)
            3'h0:    full = `DIV_110;                           // RQ8
            3'h1:    full = `DIV_300;
            3'h2:    full = `DIV_600;
            3'h3:    full = `DIV_1200;
            3'h4:    full = `DIV_2400;
            3'h5:    full = `DIV_4800;
            3'h6:    full = `DIV_9600;
            default: full = `DIV_19200;
        endcase
        bit_div = full[`DIV_W-1:0];
    end
endfunction

wire [`DIV_W-1:0] div_w   = bit_div(cfg_rate_q);
wire [`DIV_W-1:0] half_w  = {1'b0, div_w[`DIV_W-1:1]};
wire [3:0]        nbits_w = cfg_seven_q ? 4'h7 : 4'h8;          // RQ2
// Two stops only if jumpered and not eight bits with parity
wire              two_stop_w = cfg_two_stop_q &
                               !(cfg_pe_q && !cfg_seven_q);     // RQ3 RQ7

////////////////////////////////////////////////////////////////////////
// Transmitter

localparam [2:0] TX_IDLE = 3'h0;
localparam [2:0] TX_RTS  = 3'h1;
localparam [2:0] TX_STRT = 3'h2;
localparam [2:0] TX_DATA = 3'h3;
localparam [2:0] TX_PAR  = 3'h4;
localparam [2:0] TX_STOP = 3'h5;

reg  [2:0]        tx_st_q;
reg  [`DIV_W-1:0] tx_cnt_q;
reg  [3:0]        tx_bit_q;
reg  [7:0]        tx_sh_q;
reg               tx_par_q;
wire              tx_tick_w = (tx_cnt_q == div_w - 18'h1);

always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
        tx_st_q  <= TX_IDLE;
        tx_cnt_q <= 18'h0;
        tx_bit_q <= 4'h0;
        tx_sh_q  <= 8'h0;
        tx_par_q <= 1'b0;
        tx_ready <= 1'b0;
        txd      <= 1'b1;
        rts      <= 1'b0;
        dtr      <= 1'b0;
    end else begin
        dtr      <= 1'b1;                                       // RQ13
        tx_ready <= 1'b0;
        tx_cnt_q <= tx_tick_w ? 18'h0 : tx_cnt_q + 18'h1;
        case (tx_st_q)
            TX_IDLE: begin
                txd      <= 1'b1;
                rts      <= 1'b0;
                tx_cnt_q <= 18'h0;
                // Handshake inputs deliberately not consulted
                if (!cfg_take_q) begin
                    tx_ready <= 1'b1;                           // RQ14
                end
                if (tx_valid && tx_ready) begin
                    tx_ready <= 1'b0;
                    tx_sh_q  <= tx_data;
                    tx_par_q <= ~cfg_even_q;                    // RQ4
                    rts      <= 1'b1;                           // RQ12
                    tx_st_q  <= TX_RTS;
                end
            end
            TX_RTS: begin
                // One bit time of lead from rts to start bit
                if (tx_tick_w) begin
                    txd     <= 1'b0;                            // RQ16
                    tx_st_q <= TX_STRT;
                end
            end
            TX_STRT: begin
                if (tx_tick_w) begin
                    txd      <= tx_sh_q[0];                     // RQ11
                    tx_par_q <= tx_par_q ^ tx_sh_q[0];
                    tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                    tx_bit_q <= 4'h1;
                    tx_st_q  <= TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_tick_w) begin
                    if (tx_bit_q == nbits_w) begin
                        if (cfg_pe_q) begin
                            txd     <= tx_par_q;                // RQ5
                            tx_st_q <= TX_PAR;
                        end else begin
                            txd      <= 1'b1;                   // RQ6
                            tx_bit_q <= 4'h0;
                            tx_st_q  <= TX_STOP;
                        end
                    end else begin
                        txd      <= tx_sh_q[0];                 // RQ16
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                    end
                end
            end
            TX_PAR: begin
                if (tx_tick_w) begin
                    txd      <= 1'b1;
                    tx_bit_q <= 4'h0;
                    tx_st_q  <= TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_tick_w) begin
                    if (two_stop_w && tx_bit_q == 4'h0) begin
                        tx_bit_q <= 4'h1;                       // RQ3
                    end else begin
                        rts     <= 1'b0;
                        tx_st_q <= TX_IDLE;
                    end
                end
            end
            default: tx_st_q <= TX_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Receiver

// Three stages; a level counts once the second and third agree
reg  [2:0] rx_sync_q;
reg        rx_lvl_q;

always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
        rx_sync_q <= 3'h7;
        rx_lvl_q  <= 1'b1;
    end else begin
        rx_sync_q <= {rx_sync_q[1:0], rxd};
        if (rx_sync_q[1] == rx_sync_q[2]) begin
            rx_lvl_q <= rx_sync_q[2];
        end
    end
end

localparam [2:0] RX_IDLE = 3'h0;
localparam [2:0] RX_STRT = 3'h1;
localparam [2:0] RX_DATA = 3'h2;
localparam [2:0] RX_PAR  = 3'h3;
localparam [2:0] RX_STOP = 3'h4;

reg  [2:0]        rx_st_q;
reg  [`DIV_W-1:0] rx_cnt_q;
reg  [3:0]        rx_bit_q;
reg  [7:0]        rx_sh_q;
reg               rx_par_q;
wire              rx_tick_w = (rx_cnt_q == div_w - 18'h1);

// Receiver stop check is one bit only; a second stop is idle line
always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
        rx_st_q       <= RX_IDLE;
        rx_cnt_q      <= 18'h0;
        rx_bit_q      <= 4'h0;
        rx_sh_q       <= 8'h0;
        rx_par_q      <= 1'b0;
        rx_data       <= 8'h0;
        rx_valid      <= 1'b0;
        rx_parity_err <= 1'b0;
        rx_frame_err  <= 1'b0;
    end else begin
        rx_valid <= 1'b0;
        rx_cnt_q <= rx_tick_w ? 18'h0 : rx_cnt_q + 18'h1;
        case (rx_st_q)
            RX_IDLE: begin
                rx_cnt_q <= 18'h0;
                if (!rx_lvl_q && !cfg_take_q) begin
                    rx_st_q <= RX_STRT;
                end
            end
            RX_STRT: begin
                // Half a bit in: confirm start and realign to centre
                if (rx_cnt_q == half_w) begin
                    rx_cnt_q <= 18'h0;                          // RQ17
                    rx_bit_q <= 4'h0;
                    rx_sh_q  <= 8'h0;
                    rx_par_q <= ~cfg_even_q;                    // RQ4
                    rx_st_q  <= rx_lvl_q ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_tick_w) begin
                    rx_sh_q  <= cfg_seven_q ?
                                {1'b0, rx_lvl_q, rx_sh_q[6:1]} :
                                {rx_lvl_q, rx_sh_q[7:1]};       // RQ2 RQ16
                    rx_par_q <= rx_par_q ^ rx_lvl_q;
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q == nbits_w - 4'h1) begin
                        rx_st_q <= cfg_pe_q ? RX_PAR : RX_STOP; // RQ5 RQ6
                    end
                end
            end
            RX_PAR: begin
                if (rx_tick_w) begin
                    rx_par_q <= rx_par_q ^ rx_lvl_q;
                    rx_st_q  <= RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_tick_w) begin
                    rx_data       <= rx_sh_q;
                    rx_valid      <= 1'b1;
                    rx_parity_err <= cfg_pe_q & rx_par_q;       // RQ10 RQ17
                    rx_frame_err  <= ~rx_lvl_q;                 // RQ17
                    rx_st_q       <= RX_IDLE;
                end
            end
            default: rx_st_q <= RX_IDLE;
        endcase
    end
end

endmodule // serial_port

`default_nettype wire

// ==== sim/serial_port_properties.sv ====
// Pin-level checks for the serial port.
// Assumes binding to serial_port; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module serial_port_properties (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       txd,
    input wire logic       rts,
    input wire logic       dtr,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_parity_err,
    input wire logic       rx_frame_err
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////
    term_ready_a: assert property (reset_n [*4] |-> dtr)
        else $error("dtr low after reset");
    rts_lead_a: assert property ($rose(rts) |-> txd [*8])
        else $error("start bit without rts lead");
    rts_cover_a: assert property (!txd |-> rts)
        else $error("txd low without rts");
    accept_rts_a: assert property (tx_valid && tx_ready |=> rts && !tx_ready)
        else $error("accept did not raise rts");
    ready_idle_a: assert property (tx_ready |-> !rts)
        else $error("ready while sending");
    start_len_a: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    idle_mark_a: assert property ($fell(rts) |-> txd [*8])
        else $error("line not at mark after frame");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid longer than one cycle");
    rx_hold_a: assert property (!rx_valid |-> $stable({rx_data,
        rx_parity_err, rx_frame_err}))
        else $error("rx result changed without rx_valid");
endmodule // serial_port_properties
`default_nettype wire

// ==== sim/host_line.sv ====
// Host terminal model: decodes txd, drives rxd with one frame.
// Assumes the bench sets div, nb, pe and pev before each reset.
`timescale 1ns/100ps
`default_nettype none
module host_line (
    input  wire logic core_clk,
    input  wire logic txd,
    output var  logic rxd
);
    int         div = 1302;
    int         nb = 8;
    logic       pe = 1'b0;
    logic       pev = 1'b0;
    logic [7:0] got;
    logic       got_par;
    logic       got_stop;
    int         got_n = 0;
    ////////////////////////////////////////////////////////////////////
    // Centre sampling; only the first stop bit is looked at
    initial begin
        rxd = 1'b1;
        forever begin
            @(negedge txd);
            got = 8'h00;
            repeat (div / 2) @(posedge core_clk);
            for (int i = 0; i < nb; i++) begin
                repeat (div) @(posedge core_clk);
                got[i] = txd;
            end
            if (pe) begin
                repeat (div) @(posedge core_clk);
                got_par = txd;
            end
            repeat (div) @(posedge core_clk);
            got_stop = txd;
            got_n++;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic put(input logic v);
        rxd = v;
        repeat (div) @(posedge core_clk);
        #1;
    endtask
    // One frame per reset keeps clear of the device's handling time
    task automatic send(input logic [7:0] b, input logic flip,
                        input logic bad_stop);
        put(1'b0);
        for (int i = 0; i < nb; i++) put(b[i]);
        if (pe) put((^b[6:0]) ^ (b[7] & (nb == 8)) ^ !pev ^ flip);
        put(!bad_stop);
        rxd = 1'b1;
    endtask
endmodule // host_line
`default_nettype wire

// ==== sim/tb_serial_port.sv ====
// Bench for serial_port: three jumper set-ups, one frame each way.
// Assumes host_line on the line side; 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_serial_port;
    logic       core_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [6:0] jmp = 7'h00;
    logic       dsr_n = 1'b1;
    logic       cts_n = 1'b1;
    logic [7:0] tx_data = 8'h00;
    logic       tx_valid = 1'b0;
    wire        tx_ready, txd, rts, dtr, rxd;
    wire        rx_valid, rx_parity_err, rx_frame_err;
    wire  [7:0] rx_data;
    logic [9:0] cap = 10'h000;
    int         rts_cnt, cyc, fail_count, n_compared;
    int         rates [8] = '{110, 300, 600, 1200, 2400, 4800, 9600, 19200};
    ////////////////////////////////////////////////////////////////////
    serial_port u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .seven_bit_word_select(jmp[6]), .two_stop_select(jmp[5]),
        .parity_sense_even_select(jmp[4]), .parity_enable_select(jmp[3]),
        .rate_select_msb(jmp[2]), .rate_select_mid(jmp[1]),
        .rate_select_lsb(jmp[0]), .rxd(rxd), .dsr_n(dsr_n),
        .cts_n(cts_n), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .txd(txd), .rts(rts), .dtr(dtr),
        .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err));
    host_line u_host (.core_clk(core_clk), .txd(txd), .rxd(rxd));
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (rts === 1'b1) rts_cnt++;
        if (rx_valid === 1'b1) cap <= {rx_parity_err, rx_frame_err, rx_data};
        if (cyc == 90000) begin
            fail_count++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic send(input logic [7:0] b);
        tx_data = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(posedge core_clk) #1;
        @(posedge core_clk) #1;
        tx_valid = 1'b0;
    endtask
    // Jumper order {word, stop, sense, parity, rate msb..lsb}
    task automatic run(input logic [6:0] j, input logic [7:0] tb,
                       input logic [7:0] hb, input logic flip,
                       input logic bad);
        int nb, s, d, n0, t;
        logic pe;
        logic [7:0] m, mh;
        nb = j[6] ? 7 : 8;
        pe = j[3];
        s = (j[5] && !(pe && nb == 8)) ? 2 : 1;
        d = 25000000 / rates[j[2:0]];
        m = (nb == 7) ? (tb & 8'h7f) : tb;
        mh = (nb == 7) ? (hb & 8'h7f) : hb;
        u_host.div = d;
        u_host.nb = nb;
        u_host.pe = pe;
        u_host.pev = j[4];
        jmp = j;
        reset_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 reset_n = 1'b1;
        while (tx_ready !== 1'b1) @(posedge core_clk) #1;
        jmp = ~j;
        rts_cnt = 0;
        n0 = u_host.got_n;
        fork
            send(tb);
            u_host.send(hb, flip, bad);
        join
        while (u_host.got_n == n0 || tx_ready !== 1'b1) @(posedge core_clk) #1;
        t = (2 + nb + pe + s) * d;
        chk("tx data", m, u_host.got);
        if (pe) chk("tx parity", ^m ^ !j[4], u_host.got_par);
        chk("tx stop", 1, u_host.got_stop);
        chk("rts span", 1, rts_cnt > t - 4 && rts_cnt < t + 4);
        chk("rx data", mh, cap[7:0]);
        chk("rx parity", pe & flip, cap[9]);
        chk("rx frame", bad, cap[8]);
        chk("dtr", 1, dtr);
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        run(7'h7f, 8'hc5, 8'h5a, 1'b0, 1'b0);
        dsr_n = 1'b0;
        cts_n = 1'b0;
        run(7'h2f, 8'h3c, 8'ha7, 1'b1, 1'b0);
        cts_n = 1'b1;
        run(7'h16, 8'h81, 8'h7e, 1'b1, 1'b1);
        complete_run();
    end
endmodule // tb_serial_port
bind serial_port serial_port_properties u_props (.core_clk(core_clk),
    .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .txd(txd), .rts(rts), .dtr(dtr), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err));
`default_nettype wire
